// >>> hw/reset_timer_defines.svh
// Timing constants and variant codes for the dual-key reset timer.
// Assumes inclusion by bare name from hw/ sources.
`ifndef RESET_TIMER_DEFINES_SVH
`define RESET_TIMER_DEFINES_SVH

`define CLK_PERIOD_NS 10
// Nominal times in microseconds
`define DELAY_SHORT_US 7500000
`define DELAY_LONG_US 11250000
`define DELAY_FIX_A_US 7500000
`define DELAY_FIX_B_US 10000000
`define DELAY_FIX_C_US 3000000
`define REL_FIX_A_US 234000
`define REL_FIX_B_US 313000
`define REL_FIX_C_US 78000
`define REL_FIX_D_US 187500
// Cycle counts derived from time and clock period
`define US_TO_CYC(t) ((64'(t) * 64'd1000) / 64'(`CLK_PERIOD_NS))

`endif

// >>> hw/reset_timer_pkg.sv
// Types shared by the dual-key reset timer.
// Assumes no other package.
`default_nettype none
package reset_timer_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_COUNT = 2'b01,
        ST_ASSERT = 2'b11,
        ST_WAIT = 2'b10
    } timer_state_t;

    typedef struct packed {
        logic key_a_n;
        logic key_b_n;
    } keys_t;
endpackage
`default_nettype wire

// >>> hw/cycle_counter.sv
// Up-counter from zero to a programmable target with terminal flag.
// Assumes a synchronous active-high reset.
`default_nettype none
module cycle_counter #(
    parameter int WIDTH = 40
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic run,
    input wire logic [WIDTH-1:0] target,
    output logic done
);
    logic [WIDTH-1:0] count_ff;

    always_ff @(posedge clk) begin
        if (rst || clear || !run) begin
            count_ff <= '0;
        end else if (count_ff != target) begin
            count_ff <= count_ff + 1'b1;
        end
    end

    assign done = run && (count_ff == target);
endmodule
`default_nettype wire

// >>> hw/dual_key_reset_timer.sv
// Dual-key long-interval reset timer.
// Assumes keys, strap and clock synchronous to SYS_CLK.
`default_nettype none
`include "reset_timer_defines.svh"
module dual_key_reset_timer
    import reset_timer_pkg::*;
#(
    // 1: selectable delay by strap; 0: fixed delay with auto release
    parameter bit SELECTABLE = 1'b1,
    parameter longint DELAY_FIX_US = `DELAY_FIX_A_US,
    parameter longint REL_FIX_US = `REL_FIX_A_US,
    parameter longint DELAY_SHORT_US = `DELAY_SHORT_US,
    parameter longint DELAY_LONG_US = `DELAY_LONG_US,
    parameter int CNT_W = 40
) (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic KEY_IN_A_N,
    input wire logic KEY_IN_B_N,
    input wire logic DELAY_SEL,
    output logic RST_OUT
);
    // ****************************************
    // Derived counts
    // ****************************************
    localparam longint DLY_SHORT_CYC = `US_TO_CYC(DELAY_SHORT_US);
    localparam longint DLY_LONG_CYC = `US_TO_CYC(DELAY_LONG_US);
    localparam longint DLY_FIX_CYC = `US_TO_CYC(DELAY_FIX_US);
    localparam longint REL_FIX_CYC = `US_TO_CYC(REL_FIX_US);

    initial begin
        if (DLY_SHORT_CYC < 2 || DLY_LONG_CYC < 2 || DLY_FIX_CYC < 2 || REL_FIX_CYC < 2) begin
            $error("Timing counts too small");
        end
        if (DLY_LONG_CYC >= (64'd1 << CNT_W) || DLY_FIX_CYC >= (64'd1 << CNT_W)) begin
            $error("Counter too narrow");
        end
    end

    // ****************************************
    // Key and strap capture
    // ****************************************
    keys_t keys;
    logic both_low;
    logic sel_ff;
    logic strap_taken_ff;
    timer_state_t state_ff;
    timer_state_t nxt_state;
    logic [CNT_W-1:0] target;
    logic done;
    logic rst_out_ff;

    assign keys = '{key_a_n: KEY_IN_A_N, key_b_n: KEY_IN_B_N};
    assign both_low = !keys.key_a_n && !keys.key_b_n;

    // Strap caught once after reset release
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            strap_taken_ff <= 1'b0;
            sel_ff <= 1'b0;
        end else if (!strap_taken_ff) begin
            strap_taken_ff <= 1'b1;
            sel_ff <= DELAY_SEL;
        end
    end

    // ****************************************
    // Target selection
    // ****************************************
    always_comb begin
        if (state_ff == ST_ASSERT) begin
            target = CNT_W'(REL_FIX_CYC - 1);
        end else if (SELECTABLE) begin
            target = sel_ff ? CNT_W'(DLY_LONG_CYC - 1) : CNT_W'(DLY_SHORT_CYC - 1);
        end else begin
            target = CNT_W'(DLY_FIX_CYC - 1);
        end
    end

    cycle_counter #(
        .WIDTH(CNT_W)
    ) u_counter (
        .clk(SYS_CLK),
        .rst(RESET),
        .clear(nxt_state != state_ff),
        .run((state_ff == ST_COUNT) || (state_ff == ST_ASSERT && !SELECTABLE)),
        .target(target),
        .done(done)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (both_low && strap_taken_ff) begin
                    nxt_state = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (!both_low) begin
                    nxt_state = ST_IDLE;
                end else if (done) begin
                    nxt_state = ST_ASSERT;
                end
            end
            ST_ASSERT: begin
                if (!both_low) begin
                    nxt_state = ST_IDLE;
                end else if (!SELECTABLE && done) begin
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!both_low) begin
                    nxt_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Reset output held while asserted state continues
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            rst_out_ff <= 1'b0;
        end else begin
            rst_out_ff <= (nxt_state == ST_ASSERT);
        end
    end

    assign RST_OUT = rst_out_ff;
endmodule
`default_nettype wire

// >>> verif/key_pad_model.sv
// Two user keys with pull-ups.
// Assumes commands change just after a clock edge.
`default_nettype none
module key_pad_model
    import reset_timer_pkg::*;
(
    input wire logic press_a,
    input wire logic press_b,
    input wire logic single,
    output var keys_t keys
);
    // Released key reads high, except key B while single is set
    assign keys.key_a_n = ~press_a;
    assign keys.key_b_n = single ? 1'b0 : ~press_b;
endmodule
`default_nettype wire

// >>> verif/reset_timer_sva.sv
// Assertions on the reset timer pins.
// Assumes a bind to the top module.
`default_nettype none
module reset_timer_chk #(
    parameter longint DELAY_SHORT_US = 1,
    parameter longint DELAY_LONG_US = 2
) (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic KEY_IN_A_N,
    input wire logic KEY_IN_B_N,
    input wire logic DELAY_SEL,
    input wire logic RST_OUT
);
    logic [15:0] low_ff;
    wire logic hi = KEY_IN_A_N | KEY_IN_B_N;
    wire logic [15:0] lim = 16'(DELAY_SEL ? DELAY_LONG_US * 100 : DELAY_SHORT_US * 100);
    // Edges with both keys low
    always_ff @(posedge SYS_CLK) low_ff <= (RESET || hi) ? 16'h0000 : low_ff + 16'h0001;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    property p_dly; $rose(RST_OUT) |-> $past(low_ff) == lim; endproperty
    a_dly: assert property (p_dly) else $error("bad delay");
    property p_early; low_ff < lim |=> !RST_OUT; endproperty
    a_early: assert property (p_early) else $error("early");
    property p_hold; RST_OUT && !hi |=> RST_OUT; endproperty
    a_hold: assert property (p_hold) else $error("dropped");
    property p_rel; RST_OUT && hi |-> ##[1:2] !RST_OUT; endproperty
    a_rel: assert property (p_rel) else $error("stuck");
    property p_fall; $fell(RST_OUT) |-> $past(hi) || $past(hi, 2); endproperty
    a_fall: assert property (p_fall) else $error("bad fall");
    property p_rst; $past(RESET) |-> !RST_OUT; endproperty
    a_rst: assert property (p_rst) else $error("not idle");
    property p_rise; $rose(RST_OUT) |-> $past(!hi, 2); endproperty
    a_rise: assert property (p_rise) else $error("bad rise");
    property p_abort; $rose(hi) && !RST_OUT |=> !RST_OUT [*2]; endproperty
    a_abort: assert property (p_abort) else $error("no abort");
endmodule
bind dual_key_reset_timer reset_timer_chk #(.DELAY_SHORT_US(DELAY_SHORT_US), .DELAY_LONG_US(DELAY_LONG_US)) u_chk (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .KEY_IN_A_N(KEY_IN_A_N), .KEY_IN_B_N(KEY_IN_B_N),
    .DELAY_SEL(DELAY_SEL), .RST_OUT(RST_OUT));
`default_nettype wire

// >>> verif/dual_key_reset_timer_test.sv
// Self-checking bench for the reset timer.
// Assumes the key model; delays shortened to 100 and 200 cycles.
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; $display("wrong value %s %0h %0h", n, e, g); end end
module dual_key_reset_timer_test
    import reset_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, rst = 1'b1, sel = 1'b0, pa = 1'b0, pb = 1'b0, sgl = 1'b0, rst_out;
    keys_t kp;
    int fails = 0, comparisons = 0;
    always #5 sys_clk = ~sys_clk;
    key_pad_model u_key_pad_model (.press_a(pa), .press_b(pb), .single(sgl), .keys(kp));
    dual_key_reset_timer #(.SELECTABLE(1'b1), .DELAY_SHORT_US(1), .DELAY_LONG_US(2)) u_dual_key_reset_timer (
        .SYS_CLK(sys_clk), .RESET(rst), .KEY_IN_A_N(kp.key_a_n), .KEY_IN_B_N(kp.key_b_n),
        .DELAY_SEL(sel), .RST_OUT(rst_out));
    task automatic finish_test;
        if (fails == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic press(input logic a, input logic b);
        @(posedge sys_clk);
        pa <= a;
        pb <= b;
    endtask
    task automatic do_reset(input logic s);
        @(posedge sys_clk);
        rst <= 1'b1;
        sel <= s;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        `CHK("idle", 1'b0, rst_out)
    endtask
    task automatic meas(input int d);
        int n;
        n = 0;
        press(1'b1, 1'b1);
        while (rst_out !== 1'b1 && n < 400) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        `CHK("delay", d, n)
    endtask
    task automatic t_hold;
        meas(101);
        repeat (50) @(posedge sys_clk);
        `CHK("held", 1'b1, rst_out)
        press(1'b1, 1'b0);
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK("released", 1'b0, rst_out)
    endtask
    task automatic t_abort;
        press(1'b0, 1'b0);
        press(1'b1, 1'b1);
        repeat (60) @(posedge sys_clk);
        press(1'b0, 1'b1);
        repeat (150) @(posedge sys_clk);
        `CHK("aborted", 1'b0, rst_out)
        sgl <= 1'b1;
        meas(101);
    endtask
    task automatic t_strap;
        press(1'b0, 1'b0);
        sgl <= 1'b0;
        do_reset(1'b1);
        meas(201);
    endtask
    initial begin
        do_reset(1'b0);
        t_hold;
        t_abort;
        t_strap;
        finish_test;
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        fails++;
        finish_test;
    end
endmodule
`default_nettype wire
